// ==== rtl/ild_divider.v ====
// programmable divider: one output pulse per ratio input events
`timescale 1ns/1ps
module ild_divider #(
	parameter W = 14
) (
	input  wire         i_clk_sys,
	input  wire         i_sys_rst,
	input  wire         i_restart,
	input  wire         i_event,
	input  wire [W-1:0] i_ratio,
	output reg          o_tick
);
	reg [W-1:0] count_reg;

	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count_reg <= {W{1'b0}};
			o_tick    <= 1'b0;
		end else if (i_restart) begin
			count_reg <= {W{1'b0}};
			o_tick    <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_event) begin
				// ratio of zero or one acts as one: never stalls
				if (count_reg + {{(W-1){1'b0}}, 1'b1} >= i_ratio) begin
					count_reg <= {W{1'b0}};
					o_tick    <= 1'b1;
				end else begin
					count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ==== rtl/ild_pll_control.v ====
// integer-n synthesizer control: serial port, dividers, fast lock, lock detect
`timescale 1ns/1ps
`include "ild_regs.vh"
module ild_pll_control #(
	parameter PHASE_WIN = `ILD_PHASE_WIN
) (
	input  wire       i_clk_sys,
	input  wire       i_sys_rst,
	input  wire       i_ser_clk,
	input  wire       i_ser_data,
	input  wire       i_load_strobe,
	input  wire       i_core_power_enable,
	input  wire       i_synth_active_enable,
	input  wire       i_rf_in,
	input  wire       i_reference_clock_in,
	output reg        o_lock_detect,
	output reg        o_loop_switch_closed,
	output reg  [3:0] o_pump_code,
	output reg  [4:0] o_pump_units,
	output reg        o_pump_hiz,
	output reg        o_pump_up,
	output reg        o_pump_down,
	output reg        o_modulus_high,
	output reg        o_compare_tick
);
	reg [23:0] shift_reg;
	reg        ser_clk_d_reg;
	reg        load_d_reg;
	reg        synth_d_reg;
	reg        rf_d_reg;
	reg        ref_d_reg;
	reg [19:0] stage_cp_reg;
	reg [19:0] stage_refpre_reg;
	reg [19:0] ab_reg;
	reg [19:0] cp_reg;
	reg [19:0] refpre_reg;
	reg [19:0] func_reg;
	reg        commit_reg;
	reg [5:0]  a_cnt_reg;
	reg [12:0] b_cnt_reg;
	reg        fb_tick_reg;
	reg [12:0] fast_cnt_reg;
	reg        up_reg;
	reg        down_reg;
	reg [7:0]  err_cnt_reg;
	reg [5:0]  good_cnt_reg;
	reg [5:0]  bad_cnt_reg;
	reg        dig_lock_reg;

	wire       normal_mode = i_core_power_enable & i_synth_active_enable;
	wire       ser_rise    = i_ser_clk & ~ser_clk_d_reg;
	wire       load_rise   = i_load_strobe & ~load_d_reg;
	wire       synth_rise  = i_synth_active_enable & ~synth_d_reg;
	wire       rf_rise     = i_rf_in & ~rf_d_reg;
	wire       ref_rise    = i_reference_clock_in & ~ref_d_reg;
	wire [3:0] wr_addr     = shift_reg[`ILD_ADDR_HI:`ILD_ADDR_LO];
	wire [19:0] wr_data    = shift_reg[`ILD_DATA_HI:`ILD_DATA_LO];
	wire [5:0] a_val       = ab_reg[`ILD_A_HI:`ILD_A_LO];
	wire [12:0] b_val      = ab_reg[`ILD_B_HI:`ILD_B_LO];
	wire [13:0] r_val      = refpre_reg[`ILD_R_HI:`ILD_R_LO];
	wire [1:0] mod_sel     = refpre_reg[`ILD_MOD_HI:`ILD_MOD_LO];
	wire       speedup     = func_reg[`ILD_SPEEDUP_BIT];
	wire       ld_analog   = func_reg[`ILD_LDSEL_BIT];
	wire       ref_tick;
	wire       pres_tick;
	reg  [6:0] p_val;
	reg  [5:0] lock_n;

	// modulus 11 is not allowed; it falls back to the smallest modulus
	always @* begin
		case (mod_sel)
			`ILD_MOD_8:  p_val = `ILD_P_8;
			`ILD_MOD_16: p_val = `ILD_P_16;
			`ILD_MOD_32: p_val = `ILD_P_32;
			default:     p_val = `ILD_P_8;
		endcase
	end

	always @* begin
		case (func_reg[`ILD_LCNT_HI:`ILD_LCNT_LO])
			2'h0:    lock_n = `ILD_LCNT_7;
			2'h1:    lock_n = `ILD_LCNT_15;
			2'h2:    lock_n = `ILD_LCNT_31;
			default: lock_n = `ILD_LCNT_63;
		endcase
	end

	// input edge history; all pins are sampled as synchronous levels
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ser_clk_d_reg <= 1'b0;
			load_d_reg    <= 1'b0;
			synth_d_reg   <= 1'b0;
			rf_d_reg      <= 1'b0;
			ref_d_reg     <= 1'b0;
		end else begin
			ser_clk_d_reg <= i_ser_clk;
			load_d_reg    <= i_load_strobe;
			synth_d_reg   <= i_synth_active_enable;
			rf_d_reg      <= i_rf_in;
			ref_d_reg     <= i_reference_clock_in;
		end
	end

	// serial port; ignored in power-down since the core has no supply
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			shift_reg        <= 24'h000000;
			stage_cp_reg     <= `ILD_WORD_RST;
			stage_refpre_reg <= `ILD_WORD_RST;
			ab_reg           <= `ILD_WORD_RST;
			cp_reg           <= `ILD_WORD_RST;
			refpre_reg       <= `ILD_WORD_RST;
			func_reg         <= `ILD_WORD_RST;
			commit_reg       <= 1'b0;
		end else begin
			commit_reg <= 1'b0;
			if (i_core_power_enable & ~i_load_strobe & ser_rise) begin
				shift_reg <= {shift_reg[`ILD_WORD_BITS-2:0], i_ser_data};
			end
			// settings only change on writes, never on power pins
			if (i_core_power_enable & load_rise) begin
				case (wr_addr)
					`ILD_ADDR_CP:     stage_cp_reg <= wr_data;
					`ILD_ADDR_REFPRE: stage_refpre_reg <= wr_data;
					`ILD_ADDR_FUNC:   func_reg <= wr_data;
					`ILD_ADDR_AB: begin
						ab_reg     <= wr_data;
						cp_reg     <= stage_cp_reg;
						refpre_reg <= stage_refpre_reg;
						commit_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// reference divider gives the comparison clock
	ild_divider #(
		.W(14)
	) u_ref_div (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_restart (~normal_mode | commit_reg),
		.i_event   (ref_rise),
		.i_ratio   (r_val),
		.o_tick    (ref_tick)
	);

	// dual-modulus prescaler; upper modulus while swallow count remains
	ild_divider #(
		.W(7)
	) u_prescaler (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_restart (~normal_mode | commit_reg),
		.i_event   (rf_rise),
		.i_ratio   ((a_cnt_reg != 6'h00) ? p_val + 7'h01 : p_val),
		.o_tick    (pres_tick)
	);

	// swallow and program counters: total ratio p*b + a
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			a_cnt_reg   <= 6'h00;
			b_cnt_reg   <= 13'h0000;
			fb_tick_reg <= 1'b0;
		end else if (~normal_mode | commit_reg) begin
			a_cnt_reg   <= a_val;
			b_cnt_reg   <= b_val;
			fb_tick_reg <= 1'b0;
		end else begin
			fb_tick_reg <= 1'b0;
			if (pres_tick) begin
				if (b_cnt_reg <= 13'h0001) begin
					a_cnt_reg   <= a_val;
					b_cnt_reg   <= b_val;
					fb_tick_reg <= 1'b1;
				end else begin
					b_cnt_reg <= b_cnt_reg - 13'h0001;
					if (a_cnt_reg != 6'h00) begin
						a_cnt_reg <= a_cnt_reg - 6'h01;
					end
				end
			end
		end
	end

	// fast lock timer counts comparison periods
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fast_cnt_reg <= 13'h0000;
		end else if (speedup & (commit_reg | (synth_rise & i_core_power_enable))) begin
			fast_cnt_reg <= func_reg[`ILD_FAST_HI:`ILD_FAST_LO];
		end else if (~speedup) begin
			fast_cnt_reg <= 13'h0000;
		end else if (ref_tick & (fast_cnt_reg != 13'h0000)) begin
			fast_cnt_reg <= fast_cnt_reg - 13'h0001;
		end
	end

	// phase detector and phase-error measurement
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			up_reg       <= 1'b0;
			down_reg     <= 1'b0;
			err_cnt_reg  <= 8'h00;
			good_cnt_reg <= 6'h00;
			bad_cnt_reg  <= 6'h00;
			dig_lock_reg <= 1'b0;
		end else if (~normal_mode | commit_reg) begin
			up_reg       <= 1'b0;
			down_reg     <= 1'b0;
			err_cnt_reg  <= 8'h00;
			good_cnt_reg <= 6'h00;
			bad_cnt_reg  <= 6'h00;
			dig_lock_reg <= 1'b0;
		end else if ((up_reg | ref_tick) & (down_reg | fb_tick_reg)) begin
			// both edges seen: one comparison done, the error width judged
			up_reg      <= 1'b0;
			down_reg    <= 1'b0;
			err_cnt_reg <= 8'h00;
			if (err_cnt_reg < PHASE_WIN) begin
				bad_cnt_reg <= 6'h00;
				if (good_cnt_reg >= lock_n) begin
					dig_lock_reg <= 1'b1;
				end else begin
					good_cnt_reg <= good_cnt_reg + 6'h01;
					dig_lock_reg <= dig_lock_reg | (good_cnt_reg + 6'h01 >= lock_n);
				end
			end else begin
				good_cnt_reg <= 6'h00;
				if (bad_cnt_reg + 6'h01 >= lock_n) begin
					dig_lock_reg <= 1'b0;
					bad_cnt_reg  <= lock_n;
				end else begin
					bad_cnt_reg <= bad_cnt_reg + 6'h01;
				end
			end
		end else begin
			up_reg   <= up_reg | ref_tick;
			down_reg <= down_reg | fb_tick_reg;
			// saturating width counter; a stuck edge still reads as large
			if ((up_reg | down_reg) & (err_cnt_reg != 8'hFF)) begin
				err_cnt_reg <= err_cnt_reg + 8'h01;
			end
		end
	end

	// outputs, all registered
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_lock_detect        <= 1'b0;
			o_loop_switch_closed <= 1'b0;
			o_pump_code          <= 4'h0;
			o_pump_units         <= 5'h01;
			o_pump_hiz           <= 1'b1;
			o_pump_up            <= 1'b0;
			o_pump_down          <= 1'b0;
			o_modulus_high       <= 1'b0;
			o_compare_tick       <= 1'b0;
		end else begin
			o_lock_detect  <= ld_analog ? ~(up_reg | down_reg) : dig_lock_reg;
			o_modulus_high <= normal_mode & (a_cnt_reg != 6'h00);
			o_compare_tick <= ref_tick;
			// power-down and power-save both float the pump
			o_pump_hiz     <= ~normal_mode;
			o_pump_up      <= normal_mode & up_reg & ~down_reg;
			o_pump_down    <= normal_mode & down_reg & ~up_reg;
			if (speedup & (fast_cnt_reg != 13'h0000)) begin
				o_loop_switch_closed <= normal_mode;
				o_pump_code  <= cp_reg[`ILD_BPUMP_HI:`ILD_BPUMP_LO];
				o_pump_units <= {1'b0, cp_reg[`ILD_BPUMP_HI:`ILD_BPUMP_LO]} + 5'h01;
			end else begin
				o_loop_switch_closed <= 1'b0;
				o_pump_code  <= cp_reg[`ILD_NPUMP_HI:`ILD_NPUMP_LO];
				o_pump_units <= {1'b0, cp_reg[`ILD_NPUMP_HI:`ILD_NPUMP_LO]} + 5'h01;
			end
		end
	end
endmodule

// ==== rtl/ild_regs.vh ====
// address map, field positions and constants for the integer pll control block
`ifndef ILD_REGS_VH
`define ILD_REGS_VH
`define ILD_WORD_BITS     24
`define ILD_ADDR_HI       3
`define ILD_ADDR_LO       0
`define ILD_DATA_HI       23
`define ILD_DATA_LO       4
`define ILD_ADDR_AB       4'h1
`define ILD_ADDR_CP       4'h2
`define ILD_ADDR_REFPRE   4'h3
`define ILD_ADDR_FUNC     4'h4
`define ILD_A_HI          5
`define ILD_A_LO          0
`define ILD_B_HI          18
`define ILD_B_LO          6
`define ILD_NPUMP_HI      3
`define ILD_NPUMP_LO      0
`define ILD_BPUMP_HI      9
`define ILD_BPUMP_LO      6
`define ILD_R_HI          13
`define ILD_R_LO          0
`define ILD_MOD_HI        15
`define ILD_MOD_LO        14
`define ILD_FAST_HI       12
`define ILD_FAST_LO       0
`define ILD_LDSEL_BIT     13
`define ILD_SPEEDUP_BIT   16
`define ILD_LCNT_HI       18
`define ILD_LCNT_LO       17
`define ILD_MOD_8         2'h0
`define ILD_MOD_16        2'h1
`define ILD_MOD_32        2'h2
`define ILD_P_8           7'h08
`define ILD_P_16          7'h10
`define ILD_P_32          7'h20
`define ILD_LCNT_7        6'h07
`define ILD_LCNT_15       6'h0F
`define ILD_LCNT_31       6'h1F
`define ILD_LCNT_63       6'h3F
`define ILD_PHASE_WIN     8'h04
`define ILD_WORD_RST      20'h00000
`endif

// ==== tb/ild_host_model.sv ====
// host-side model: serial writer, power pins, reference and rf sources
`timescale 1ns/1ps
module ild_host_model (
	input  wire i_clk_sys,
	output reg  o_ser_clk,
	output reg  o_ser_data,
	output reg  o_load_strobe,
	output reg  o_core_power_enable,
	output reg  o_synth_active_enable,
	output reg  o_rf_in,
	output reg  o_reference_clock_in
);
	reg [1:0] ref_div_reg;
	reg       rf_slow;
	reg       rf_skip_reg;
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_load_strobe = 1'b0;
		o_rf_in = 1'b0;
		o_core_power_enable = 1'b0;
		o_synth_active_enable = 1'b0;
		o_reference_clock_in = 1'b0;
		ref_div_reg = 2'h0;
		rf_slow = 1'b0;
		rf_skip_reg = 1'b0;
	end
	// rf period 2 cycles, 4 when slowed to break lock; reference period 4 cycles
	always @(negedge i_clk_sys) begin
		rf_skip_reg <= ~rf_skip_reg;
		if (!rf_slow || rf_skip_reg)
			o_rf_in <= ~o_rf_in;
		ref_div_reg <= ref_div_reg + 2'h1;
		o_reference_clock_in <= ref_div_reg[1];
	end
	task cycles(input integer n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task power_core;
		o_core_power_enable = 1'b1;
		cycles(1000);
	endtask
	// synth pin must already be low before the core drops
	task power_down;
		@(negedge i_clk_sys);
		o_core_power_enable = 1'b0;
	endtask
	task set_rf_slow(input reg v);
		@(posedge i_clk_sys);
		rf_slow = v;
	endtask
	task set_synth(input reg v);
		@(negedge i_clk_sys);
		o_synth_active_enable = v;
	endtask
	// leading junk bits go first so only the final 24 should count
	task send(input [3:0] addr, input [19:0] data, input integer extra);
		reg [23:0] word;
		integer    k;
		word = {data, addr};
		@(negedge i_clk_sys);
		for (k = 23 + extra; k >= 0; k = k - 1) begin
			o_ser_data = (k > 23) ? 1'b1 : word[k];
			cycles(2);
			o_ser_clk = 1'b1;
			cycles(2);
			o_ser_clk = 1'b0;
		end
		o_load_strobe = 1'b1;
		cycles(2);
		o_load_strobe = 1'b0;
		o_ser_data = ~o_ser_data;
		cycles(2);
	endtask
endmodule

// ==== tb/ild_pll_control_sva.sv ====
// port checker for the pll control block
`timescale 1ns/1ps
module ild_pll_control_sva (
	input wire       i_clk_sys,
	input wire       i_sys_rst,
	input wire       i_load_strobe,
	input wire       i_core_power_enable,
	input wire       i_synth_active_enable,
	input wire [3:0] o_pump_code,
	input wire [4:0] o_pump_units,
	input wire       o_pump_hiz,
	input wire       o_loop_switch_closed,
	input wire       o_compare_tick
);
	reg [3:0] since_reg;
	reg       load_d_reg;
	reg       synth_d_reg;
	// cycles since a load rise or synth rise, saturating
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			since_reg <= 4'hF;
			load_d_reg <= 1'b0;
			synth_d_reg <= 1'b0;
		end else begin
			load_d_reg <= i_load_strobe;
			synth_d_reg <= i_synth_active_enable;
			if ((i_load_strobe && !load_d_reg) || (i_synth_active_enable && !synth_d_reg))
				since_reg <= 4'h0;
			else if (since_reg != 4'hF)
				since_reg <= since_reg + 4'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	a_units_track: assert property (o_pump_units == {1'b0, o_pump_code} + 5'h01)
		else $error("pump units not code plus one");
	a_hiz_save: assert property (!(i_core_power_enable && i_synth_active_enable) [*3] |-> o_pump_hiz)
		else $error("pump driven outside normal mode");
	a_hiz_normal: assert property ((i_core_power_enable && i_synth_active_enable) [*5] |-> !o_pump_hiz)
		else $error("pump idle in normal mode");
	a_switch_save: assert property (!i_synth_active_enable [*5] |-> !o_loop_switch_closed)
		else $error("loop switch closed outside normal mode");
	a_write_refused: assert property (!i_core_power_enable [*6] |-> $stable(o_pump_code))
		else $error("pump code moved while powered down");
	a_tick_idle: assert property (!i_synth_active_enable [*5] |-> !o_compare_tick)
		else $error("comparison tick outside normal mode");
	a_tick_spacing: assert property (o_compare_tick |=> !o_compare_tick [*3])
		else $error("comparison ticks too close");
	a_switch_cause: assert property ($rose(o_loop_switch_closed) |-> since_reg < 4'h8)
		else $error("fast lock started without a cause");
endmodule
bind ild_pll_control ild_pll_control_sva i_sva (
	.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst),
	.i_load_strobe(i_load_strobe),
	.i_core_power_enable(i_core_power_enable),
	.i_synth_active_enable(i_synth_active_enable),
	.o_pump_code(o_pump_code),
	.o_pump_units(o_pump_units),
	.o_pump_hiz(o_pump_hiz),
	.o_loop_switch_closed(o_loop_switch_closed),
	.o_compare_tick(o_compare_tick)
);

// ==== tb/test_ild_pll_control.sv ====
// self-checking bench for the pll control block
`timescale 1ns/1ps
module test_ild_pll_control;
	reg        i_clk_sys;
	reg        i_sys_rst;
	wire       sclk, sdat, load, core, synth, rf, refc;
	wire       lock, sw, hiz, up, dn, mod_high, tick;
	wire [3:0] code;
	wire [4:0] units;
	integer    fail_count;
	integer    samples_checked;
	integer    n;
	integer    k;
	integer    m;
	ild_host_model i_host (.i_clk_sys(i_clk_sys), .o_ser_clk(sclk), .o_ser_data(sdat),
		.o_load_strobe(load), .o_core_power_enable(core), .o_synth_active_enable(synth),
		.o_rf_in(rf), .o_reference_clock_in(refc));
	ild_pll_control i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_ser_clk(sclk),
		.i_ser_data(sdat), .i_load_strobe(load), .i_core_power_enable(core),
		.i_synth_active_enable(synth), .i_rf_in(rf), .i_reference_clock_in(refc),
		.o_lock_detect(lock), .o_loop_switch_closed(sw), .o_pump_code(code),
		.o_pump_units(units), .o_pump_hiz(hiz), .o_pump_up(up), .o_pump_down(dn),
		.o_modulus_high(mod_high), .o_compare_tick(tick));
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wait_tick;
		n = 1;
		@(negedge i_clk_sys);
		while (tick !== 1'b1 && n < 300) begin
			@(negedge i_clk_sys);
			n = n + 1;
		end
	endtask
	// counts ticks while the loop switch stays closed
	task count_fast;
		n = 0;
		k = 0;
		while (sw === 1'b1 && k < 2000) begin
			if (tick === 1'b1)
				n = n + 1;
			@(negedge i_clk_sys);
			k = k + 1;
		end
		i_host.cycles(2);
	endtask
	// counts comparison ticks until the lock pin reaches level v
	task count_lock(input reg v);
		n = 0;
		k = 0;
		while (lock !== v && k < 3000) begin
			if (tick === 1'b1)
				n = n + 1;
			@(negedge i_clk_sys);
			k = k + 1;
		end
	endtask
	task hold_mod(input reg v);
		n = 0;
		while (mod_high === v && n < 600) begin
			@(negedge i_clk_sys);
			n = n + 1;
		end
	endtask
	task t_reset;
		check("hiz", hiz, 1);
		check("units", units, 1);
		check("switch", sw, 0);
	endtask
	task t_staged;
		i_host.power_core;
		check("hiz", hiz, 1);
		i_host.send(4'h2, 20'h00245, 0);
		i_host.send(4'h3, 20'h00004, 0);
		i_host.send(4'h4, 20'h02003, 0);
		check("code", code, 0);
		i_host.send(4'h1, 20'h000C0, 0);
		check("code", code, 5);
		check("units", units, 6);
		i_host.set_synth(1'b1);
		i_host.cycles(8);
		check("hiz", hiz, 0);
		check("switch", sw, 0);
		m = 0;
		for (k = 0; k < 48; k = k + 1) begin
			@(negedge i_clk_sys);
			check("lock", lock, !(up | dn));
			if (lock === 1'b0)
				m = m + 1;
		end
		check("pulse_seen", m > 0, 1);
	endtask
	task t_tick;
		wait_tick;
		wait_tick;
		check("tick_period", n, 16);
	endtask
	task t_fast;
		i_host.send(4'h4, 20'h12003, 0);
		i_host.send(4'h1, 20'h000C0, 1);
		check("switch", sw, 1);
		check("code", code, 9);
		count_fast;
		check("fast_ticks", n, 3);
		check("code", code, 5);
	endtask
	task t_synth;
		i_host.set_synth(1'b0);
		i_host.cycles(8);
		check("hiz", hiz, 1);
		i_host.set_synth(1'b1);
		i_host.cycles(6);
		check("switch", sw, 1);
		count_fast;
		check("code", code, 5);
	endtask
	task t_lock_mod;
		i_host.send(4'h4, 20'h00003, 0);
		i_host.send(4'h1, 20'h000C2, 0);
		check("lock", lock, 0);
		hold_mod(1'b1);
		hold_mod(1'b0);
		hold_mod(1'b1);
		check("mod_high_len", n, 36);
		hold_mod(1'b0);
		check("mod_low_len", n, 16);
	endtask
	// ref and feedback both 96 cycles, so every comparison is small
	task t_dig_lock;
		i_host.send(4'h3, 20'h00018, 0);
		i_host.send(4'h4, 20'h00003, 0);
		i_host.send(4'h1, 20'h00180, 0);
		count_lock(1'b1);
		check("lock_count_7", n, 7);
		i_host.send(4'h4, 20'h20003, 0);
		check("lock", lock, 1);
		i_host.send(4'h1, 20'h00180, 0);
		check("lock", lock, 0);
		count_lock(1'b1);
		check("lock_count_15", n, 15);
		i_host.send(4'h4, 20'h00003, 0);
		check("lock", lock, 1);
		i_host.set_rf_slow(1'b1);
		count_lock(1'b0);
		check("unlock_ticks", (n >= 11 && n <= 17), 1);
		check("lock", lock, 0);
		i_host.set_rf_slow(1'b0);
	endtask
	// writes while powered down must leave no trace, staged words included
	task t_power;
		i_host.set_synth(1'b0);
		i_host.power_down;
		i_host.send(4'h2, 20'h0000A, 0);
		i_host.send(4'h1, 20'h00180, 0);
		check("code", code, 5);
		check("hiz", hiz, 1);
		check("switch", sw, 0);
		i_host.power_core;
		i_host.set_synth(1'b1);
		i_host.send(4'h1, 20'h00180, 0);
		check("code", code, 5);
		check("hiz", hiz, 0);
	endtask
	task t_mid_reset;
		@(negedge i_clk_sys);
		i_sys_rst = 1'b1;
		i_host.cycles(2);
		i_sys_rst = 1'b0;
		check("code", code, 0);
		check("units", units, 1);
		check("lock", lock, 0);
		check("switch", sw, 0);
		i_host.cycles(2);
		check("hiz", hiz, 0);
		check("units", units, 1);
	endtask
	initial begin
		fail_count = 0;
		samples_checked = 0;
		i_sys_rst = 1'b1;
		repeat (6) @(negedge i_clk_sys);
		i_sys_rst = 1'b0;
		t_reset;
		t_staged;
		t_tick;
		t_fast;
		t_synth;
		t_lock_mod;
		t_dig_lock;
		t_power;
		t_mid_reset;
		end_of_test;
	end
	// whole run needs under ten thousand cycles
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fail_count = fail_count + 1;
		end_of_test;
	end
endmodule
